/* hdl/icms_edge_sync.sv */
// three-stage pin synchroniser with edge qualification
// assumes pin_in is asynchronous to clk_in
`timescale 1ns/10ps
`default_nettype none
module icms_edge_sync
  import icms_pkg::*;
(
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // raw pin
  input wire logic pin_in,
  // qualified edges, one-cycle pulses
  output var icms_edge_t edge_out
);

  logic s1_r;
  logic s2_r;
  logic s3_r;
  logic primed_r;

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      s1_r <= 1'h0;
      s2_r <= 1'h0;
      s3_r <= 1'h0;
    end else begin
      s1_r <= pin_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // first agreement after reset only loads the level, but it is taken on the reset zeros of
  // the stages, so a pin that already sits high at reset still gives a rising edge
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      primed_r <= 1'h0;
      edge_out <= '0;
    end else begin
      edge_out.rise <= 1'h0;
      edge_out.fall <= 1'h0;
      if (s2_r == s3_r) begin
        primed_r <= 1'h1;
        edge_out.level <= s3_r;
        if (primed_r && s3_r != edge_out.level) begin
          edge_out.rise <= s3_r;
          edge_out.fall <= ~s3_r;
        end
      end
    end
  end

endmodule : icms_edge_sync
`default_nettype wire

/* hdl/icms_map.svh */
// register offsets, field positions, reset values and counts of the
// capture mode block; included by the time base, the top level and the bench
// Operation
// - code 000 keeps capture disabled
// - code 001 captures every edge
// - code 010 captures falling edges only
// - code 011 captures rising edges only
// - code 100 captures every fourth rise
// - code 101 captures every sixteenth rise
// - code 110 chosen edge first, then all
// - code 111 interrupt only, low power
`ifndef ICMS_MAP_SVH
`define ICMS_MAP_SVH
`define ICMS_OFF_CTRL 8'h00
`define ICMS_OFF_STAT 8'h04
`define ICMS_OFF_MASK 8'h08
`define ICMS_OFF_CAPT 8'h0c
`define ICMS_OFF_TIME 8'h10
`define ICMS_CTRL_MODE_LSB 0
`define ICMS_CTRL_MODE_MSB 2
`define ICMS_CTRL_FIRST_BIT 3
`define ICMS_CTRL_RST 3'h0
`define ICMS_FIRST_RST 1'h0
`define ICMS_STAT_CAP_BIT 0
`define ICMS_STAT_OVF_BIT 1
`define ICMS_STAT_INT_BIT 2
`define ICMS_STAT_W 3
`define ICMS_STAT_RST 3'h0
`define ICMS_MASK_RST 3'h0
`define ICMS_DIV4_LAST 4'h3
`define ICMS_DIV16_LAST 4'hf
`define ICMS_PRE_RST 4'h0
`define ICMS_TB_DIV_DEF 1
`define ICMS_TB_W_DEF 16
`endif

/* hdl/icms_pkg.sv */
// types shared by the capture mode block
// assumes the map header supplies all numeric constants except the mode codes, which are set here
package icms_pkg;

  typedef enum logic [2:0] {
    ICMS_OFF     = 3'b000,
    ICMS_EDGE    = 3'b001,
    ICMS_FALL    = 3'b010,
    ICMS_RISE    = 3'b011,
    ICMS_DIV4    = 3'b100,
    ICMS_DIV16   = 3'b101,
    ICMS_FIRST   = 3'b110,
    ICMS_INTONLY = 3'b111
  } icms_mode_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } icms_req_t;

  typedef struct packed {
    logic rise;
    logic fall;
    logic level;
  } icms_edge_t;

endpackage : icms_pkg

/* hdl/icms_timebase.sv */
// free-running time base stamped into captures
// assumes a single clock; slower rates come from an enable divider
`timescale 1ns/10ps
`default_nettype none
`include "icms_map.svh"
module icms_timebase #(
  parameter int TB_W = `ICMS_TB_W_DEF,
  parameter int TB_DIV = `ICMS_TB_DIV_DEF
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // control
  input wire logic run_in,
  // count
  output logic [TB_W-1:0] count_out
);

  localparam int DW = (TB_DIV > 1) ? $clog2(TB_DIV) : 1;
  localparam logic [DW-1:0] DLAST = DW'(TB_DIV - 1);

  logic [DW-1:0] div_r;
  logic tick_r;

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      div_r <= '0;
      tick_r <= 1'h0;
    end else begin
      tick_r <= run_in && div_r == DLAST;
      div_r <= (!run_in || div_r == DLAST) ? '0 : div_r + DW'(1);
    end
  end

  // stopped time base holds its value so software can read it
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      count_out <= '0;
    end else if (tick_r) begin
      count_out <= count_out + TB_W'(1);
    end
  end

endmodule : icms_timebase
`default_nettype wire

/* hdl/icms_top.sv */
// capture mode selection, capture register and interrupt logic
// assumes one 20 MHz clock, a plain register port and a pin input
// that is asynchronous to the clock
//
// The plain strobed port and the register addresses were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
`include "icms_map.svh"
module icms_top
  import icms_pkg::*;
#(
  parameter int TB_W = `ICMS_TB_W_DEF,
  parameter int TB_DIV = `ICMS_TB_DIV_DEF
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // register port
  input wire icms_req_t bus_req_in,
  output logic [31:0] rdata_out,
  // capture pin and power state
  input wire logic cap_pin_in,
  input wire logic low_power_in,
  // events and interrupt
  output logic cap_evt_out,
  output logic io_evt_out,
  output logic irq_out
);

  icms_mode_t mode_r;
  logic first_rise_r;
  logic [3:0] pre_cnt_r;
  logic armed_r;
  logic [TB_W-1:0] capt_r;
  logic [`ICMS_STAT_W-1:0] stat_r;
  logic [`ICMS_STAT_W-1:0] stat_nxt;
  logic [`ICMS_STAT_W-1:0] mask_r;
  logic [`ICMS_STAT_W-1:0] mask_nxt;
  logic [`ICMS_STAT_W-1:0] set_w;
  logic [`ICMS_STAT_W-1:0] clr_w;
  logic [TB_W-1:0] tb_w;
  icms_edge_t edg_w;
  logic any_w;
  logic cap_w;
  logic io_w;
  logic ctrl_wr_w;
  logic stat_wr_w;
  logic mask_wr_w;
  logic capt_rd_w;

  icms_edge_sync u_sync (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .pin_in(cap_pin_in),
    .edge_out(edg_w)
  );

  // time base runs whenever capture is enabled
  icms_timebase #(
    .TB_W(TB_W),
    .TB_DIV(TB_DIV)
  ) u_tb (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .run_in(mode_r != ICMS_OFF),
    .count_out(tb_w)
  );

  assign any_w = edg_w.rise | edg_w.fall;
  assign ctrl_wr_w = bus_req_in.wr && bus_req_in.addr == `ICMS_OFF_CTRL;
  assign stat_wr_w = bus_req_in.wr && bus_req_in.addr == `ICMS_OFF_STAT;
  assign mask_wr_w = bus_req_in.wr && bus_req_in.addr == `ICMS_OFF_MASK;
  assign capt_rd_w = bus_req_in.rd && bus_req_in.addr == `ICMS_OFF_CAPT;

  // control register; any write restarts prescaler and first-edge wait
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      mode_r <= icms_mode_t'(`ICMS_CTRL_RST);
      first_rise_r <= `ICMS_FIRST_RST;
    end else if (ctrl_wr_w) begin
      mode_r <= icms_mode_t'(bus_req_in.wdata[`ICMS_CTRL_MODE_MSB:
                                              `ICMS_CTRL_MODE_LSB]);
      first_rise_r <= bus_req_in.wdata[`ICMS_CTRL_FIRST_BIT];
    end
  end

  // qualifying event per mode
  always_comb begin
    cap_w = 1'h0;
    io_w = 1'h0;
    unique case (mode_r)
      ICMS_OFF: cap_w = 1'h0;
      ICMS_EDGE: cap_w = any_w;
      ICMS_FALL: cap_w = edg_w.fall;
      ICMS_RISE: cap_w = edg_w.rise;
      ICMS_DIV4: cap_w = edg_w.rise && pre_cnt_r == `ICMS_DIV4_LAST;
      ICMS_DIV16: cap_w = edg_w.rise && pre_cnt_r == `ICMS_DIV16_LAST;
      ICMS_FIRST: begin
        if (armed_r) begin
          cap_w = any_w;
        end else begin
          cap_w = first_rise_r ? edg_w.rise : edg_w.fall;
        end
      end
      // flag only, and only in a low-power state
      ICMS_INTONLY: io_w = low_power_in & any_w;
    endcase
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      pre_cnt_r <= `ICMS_PRE_RST;
    end else if (ctrl_wr_w) begin
      pre_cnt_r <= `ICMS_PRE_RST;
    end else if (edg_w.rise &&
                 (mode_r == ICMS_DIV4 || mode_r == ICMS_DIV16)) begin
      pre_cnt_r <= cap_w ? `ICMS_PRE_RST : pre_cnt_r + 4'h1;
    end
  end

  // arm after the chosen first edge
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      armed_r <= 1'h0;
    end else if (ctrl_wr_w) begin
      armed_r <= 1'h0;
    end else if (mode_r == ICMS_FIRST && cap_w) begin
      armed_r <= 1'h1;
    end
  end

  // stamp the time base; a single slot, older value is lost
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      capt_r <= '0;
    end else if (cap_w) begin
      capt_r <= tb_w;
    end
  end

  // flag software; overflow when an unread capture is overwritten
  always_comb begin
    set_w = '0;
    set_w[`ICMS_STAT_CAP_BIT] = cap_w;
    set_w[`ICMS_STAT_OVF_BIT] = cap_w & stat_r[`ICMS_STAT_CAP_BIT];
    set_w[`ICMS_STAT_INT_BIT] = io_w;
    clr_w = stat_wr_w ? bus_req_in.wdata[`ICMS_STAT_W-1:0] : '0;
    clr_w[`ICMS_STAT_CAP_BIT] = clr_w[`ICMS_STAT_CAP_BIT] | capt_rd_w;
  end

  // set beats clear so an event landing with the clear is kept
  genvar gi;
  generate
    for (gi = 0; gi < `ICMS_STAT_W; gi = gi + 1) begin : g_stat
      assign stat_nxt[gi] = set_w[gi] | (stat_r[gi] & ~clr_w[gi]);
      assign mask_nxt[gi] = mask_wr_w ? bus_req_in.wdata[gi] : mask_r[gi];
      always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
          stat_r[gi] <= 1'h0;
          mask_r[gi] <= 1'h0;
        end else begin
          stat_r[gi] <= stat_nxt[gi];
          mask_r[gi] <= mask_nxt[gi];
        end
      end
    end
  endgenerate

  // level interrupt follows the next status and mask together
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      irq_out <= 1'h0;
    end else begin
      irq_out <= |(stat_nxt & mask_nxt);
    end
  end

  // event pulses for neighbouring logic
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      cap_evt_out <= 1'h0;
      io_evt_out <= 1'h0;
    end else begin
      cap_evt_out <= cap_w;
      io_evt_out <= io_w;
    end
  end

  // read data stand for one cycle only; unmapped reads return zero
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      rdata_out <= 32'h0;
    end else begin
      rdata_out <= 32'h0;
      if (bus_req_in.rd) begin
        unique case (bus_req_in.addr)
          `ICMS_OFF_CTRL: begin
            rdata_out[`ICMS_CTRL_MODE_MSB:`ICMS_CTRL_MODE_LSB] <= mode_r;
            rdata_out[`ICMS_CTRL_FIRST_BIT] <= first_rise_r;
          end
          `ICMS_OFF_STAT: rdata_out[`ICMS_STAT_W-1:0] <= stat_r;
          `ICMS_OFF_MASK: rdata_out[`ICMS_STAT_W-1:0] <= mask_r;
          `ICMS_OFF_CAPT: rdata_out[TB_W-1:0] <= capt_r;
          `ICMS_OFF_TIME: rdata_out[TB_W-1:0] <= tb_w;
          default: rdata_out <= 32'h0;
        endcase
      end
    end
  end

  // assertion helpers: the request seen at the previous edge
  logic prev_rd_r;
  logic [7:0] prev_addr_r;
  logic [`ICMS_STAT_W-1:0] prev_wdata_r;

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      prev_rd_r <= 1'h0;
      prev_addr_r <= 8'h0;
      prev_wdata_r <= '0;
    end else begin
      prev_rd_r <= bus_req_in.rd;
      prev_addr_r <= bus_req_in.addr;
      prev_wdata_r <= bus_req_in.wdata[`ICMS_STAT_W-1:0];
    end
  end

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (rst_in);

  off_mode_a: assert property (mode_r == ICMS_OFF |=> !cap_evt_out)
    else $error("capture event while disabled");

  edge_mode_a: assert property (
    mode_r == ICMS_EDGE |-> ##1 (cap_evt_out == $past(any_w)))
    else $error("edge mode missed or invented an edge");

  fall_mode_a: assert property (
    mode_r == ICMS_FALL |=> cap_evt_out == $past(edg_w.fall))
    else $error("falling mode event mismatch");

  rise_mode_a: assert property (
    mode_r == ICMS_RISE |=> cap_evt_out == $past(edg_w.rise))
    else $error("rising mode event mismatch");

  div4_cnt_a: assert property (
    mode_r == ICMS_DIV4 && edg_w.rise |->
      pre_cnt_r <= `ICMS_DIV4_LAST ##1
      cap_evt_out == ($past(pre_cnt_r) == `ICMS_DIV4_LAST))
    else $error("divide by four prescaler wrong");

  div16_cnt_a: assert property (
    mode_r == ICMS_DIV16 && !ctrl_wr_w && edg_w.rise |=>
      (cap_evt_out == ($past(pre_cnt_r) == `ICMS_DIV16_LAST)) &&
      (pre_cnt_r == 4'($past(pre_cnt_r) + 4'h1)))
    else $error("divide by sixteen prescaler wrong");

  first_edge_a: assert property (
    mode_r == ICMS_FIRST && !armed_r && any_w &&
    (first_rise_r ? edg_w.fall : edg_w.rise) |=> !cap_evt_out)
    else $error("captured before the chosen first edge");

  first_arm_a: assert property (
    mode_r == ICMS_FIRST && !ctrl_wr_w && cap_w |=>
      armed_r ##1 (mode_r != ICMS_FIRST || $past(ctrl_wr_w) || armed_r))
    else $error("first-edge mode failed to arm");

  int_only_a: assert property (
    mode_r == ICMS_INTONLY |=>
      !cap_evt_out &&
      io_evt_out == ($past(low_power_in) && $past(any_w)))
    else $error("interrupt-only mode misbehaved");

  stamp_val_a: assert property (
    cap_w |=> cap_evt_out && capt_r == $past(tb_w) &&
      stat_r[`ICMS_STAT_CAP_BIT])
    else $error("capture did not store the time base");

  irq_level_a: assert property (irq_out == |(stat_r & mask_r))
    else $error("interrupt level disagrees with status");

  rd_once_a: assert property (!bus_req_in.rd |=> rdata_out == 32'h0)
    else $error("read data held beyond one cycle");

  rd_ctrl_a: assert property (
    prev_rd_r && prev_addr_r == `ICMS_OFF_CTRL |->
      rdata_out == {28'h0, $past(first_rise_r), $past(mode_r)})
    else $error("control read back wrong");

  rd_stat_a: assert property (
    prev_rd_r && prev_addr_r == `ICMS_OFF_STAT |->
      rdata_out == 32'($past(stat_r)))
    else $error("status read back wrong");

  rd_mask_a: assert property (
    prev_rd_r && prev_addr_r == `ICMS_OFF_MASK |->
      rdata_out == 32'($past(mask_r)))
    else $error("mask read back wrong");

  rd_capt_a: assert property (
    prev_rd_r && prev_addr_r == `ICMS_OFF_CAPT |->
      rdata_out == 32'($past(capt_r)))
    else $error("capture read back wrong");

  mask_load_a: assert property (
    $past(mask_wr_w) |-> mask_r == prev_wdata_r)
    else $error("mask write did not land");

  ctrl_restart_a: assert property (
    ctrl_wr_w |=> pre_cnt_r == `ICMS_PRE_RST && !armed_r)
    else $error("control write did not restart counting");

  ovf_set_a: assert property (
    cap_w && stat_r[`ICMS_STAT_CAP_BIT] |=> stat_r[`ICMS_STAT_OVF_BIT])
    else $error("overwritten capture not flagged");

  set_wins_a: assert property (
    cap_w && (stat_wr_w || capt_rd_w) |=> stat_r[`ICMS_STAT_CAP_BIT])
    else $error("clear beat a capture in the same cycle");

  capt_clr_a: assert property (
    capt_rd_w && !cap_w |=> !stat_r[`ICMS_STAT_CAP_BIT])
    else $error("capture read did not clear its flag");

  int_flag_a: assert property (
    io_w |=> io_evt_out && stat_r[`ICMS_STAT_INT_BIT])
    else $error("interrupt-only event not flagged");

  no_io_a: assert property (
    mode_r != ICMS_INTONLY || !low_power_in |=> !io_evt_out)
    else $error("interrupt-only event outside its mode");

  edge_excl_a: assert property (
    !(edg_w.rise && edg_w.fall))
    else $error("rise and fall reported together");

  tb_hold_a: assert property (
    mode_r == ICMS_OFF ##1 mode_r == ICMS_OFF |=> tb_w == $past(tb_w))
    else $error("time base moved while disabled");

  edge_seen_c: cover property (mode_r == ICMS_EDGE ##1 cap_evt_out);
  div16_hit_c: cover property (mode_r == ICMS_DIV16 ##1 cap_evt_out);
  first_arm_c: cover property (!armed_r ##1 armed_r ##[1:40] cap_evt_out);
  set_clr_c: cover property (stat_wr_w && cap_w);
  int_only_c: cover property (io_evt_out ##1 irq_out);

endmodule : icms_top
`default_nettype wire

/* tb/icms_pin_model.sv */
// stand-in for the external signal on the capture pin
// assumes the bench seeds the random generator before any toggle
`timescale 1ns/10ps
`default_nettype none
module icms_pin_model (
  // clock
  input wire logic clk_in,
  // capture pin
  output logic pin_out
);
  initial pin_out = 1'b0;

  // edges at least three clocks apart; one clock apart the synchroniser drops both of them
  task automatic toggle(input int n);
    int gap;
    for (int i = 0; i < n; i++) begin
      gap = 3 + ($urandom % 6);
      repeat (gap) @(posedge clk_in);
      pin_out <= ~pin_out;
    end
  endtask : toggle
endmodule : icms_pin_model
`default_nettype wire

/* tb/tb_top.sv */
// self-checking bench for the capture mode block
// assumes the pin model sits on cap_pin_in and the clock is 20 MHz
`timescale 1ns/10ps
`default_nettype none
`include "icms_map.svh"
module tb_top
  import icms_pkg::*;
;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  icms_req_t req;
  logic [31:0] rdata;
  logic [31:0] d;
  logic [31:0] t1;
  logic pin;
  logic lp;
  logic cap_evt;
  logic io_evt;
  logic irq;
  int failures = 0;
  int num_checks = 0;
  int cap_cnt = 0;
  int io_cnt = 0;
  int cyc = 0;
  int cap_cyc = 0;

  icms_top #(.TB_W(16), .TB_DIV(1)) DUT (
    .clk_in(clk_in), .rst_in(rst_in), .bus_req_in(req),
    .rdata_out(rdata), .cap_pin_in(pin), .low_power_in(lp),
    .cap_evt_out(cap_evt), .io_evt_out(io_evt), .irq_out(irq)
  );
  icms_pin_model pin_m (.clk_in(clk_in), .pin_out(pin));

  always #25 clk_in = ~clk_in;

  // pulses are looked at mid-cycle, where they stand settled
  always @(negedge clk_in) begin
    cyc++;
    if (cap_evt === 1'b1) begin
      cap_cnt++;
      cap_cyc = cyc;
    end
    if (io_evt === 1'b1) io_cnt++;
  end

  task end_sim;
    if (failures == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : end_sim

  task chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_in);
    req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge clk_in);
    req <= '0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk_in);
    req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clk_in);
    req <= '0;
    #1 v = rdata;
  endtask : rd

  // captures expected from n toggles starting with the pin low
  function automatic int exp_caps(input logic [2:0] m, input logic f,
                                  input int n);
    int r;
    r = (n + 1) / 2;
    case (m)
      3'h1: return n;
      3'h2: return n / 2;
      3'h3: return r;
      3'h4: return r / 4;
      3'h5: return r / 16;
      3'h6: return f ? n : ((n > 0) ? n - 1 : 0);
      default: return 0;
    endcase
  endfunction : exp_caps

  task automatic run(input logic [2:0] m, input logic f, input int n,
                     input logic p);
    int e;
    int c0;
    int i0;
    logic ie;
    logic [31:0] v;
    e = exp_caps(m, f, n);
    ie = (m == 3'h7) && p && (n > 0);
    wr(`ICMS_OFF_CTRL, 32'h0);
    if (pin === 1'b1) pin_m.toggle(1);
    repeat (8) @(posedge clk_in);
    lp <= p;
    wr(`ICMS_OFF_STAT, 32'h7);
    wr(`ICMS_OFF_CTRL, {28'h0, f, m});
    c0 = cap_cnt;
    i0 = io_cnt;
    pin_m.toggle(n);
    repeat (8) @(posedge clk_in);
    chk(32'(cap_cnt - c0), 32'(e));
    chk({31'h0, io_cnt != i0}, {31'h0, ie});
    rd(`ICMS_OFF_STAT, v);
    chk(v & 32'h7, {29'h0, ie, e > 1, e > 0});
    rd(`ICMS_OFF_CAPT, v);
    rd(`ICMS_OFF_TIME, t1);
    // stamp lags the time base read back by one more than the cycles counted since
    if (e > 0) begin
      chk((t1 - v) & 32'hffff, 32'(cyc - cap_cyc + 1) & 32'hffff);
    end
    rd(`ICMS_OFF_STAT, v);
    chk(v & 32'h1, 32'h0);
  endtask : run

  initial begin
    repeat (100000) @(posedge clk_in);
    failures++;
    end_sim();
  end

  initial begin
    req = '0;
    lp = 1'b0;
    void'($urandom(32'h1471));
    repeat (2) @(posedge clk_in);
    rst_in <= 1'b0;
    rd(`ICMS_OFF_CTRL, d);
    chk(d, 32'h0);
    rd(`ICMS_OFF_STAT, d);
    chk(d, 32'h0);
    rd(`ICMS_OFF_MASK, d);
    chk(d, 32'h0);
    run(3'h0, 1'b0, 9, 1'b0);
    run(3'h1, 1'b0, 11, 1'b0);
    run(3'h2, 1'b0, 10, 1'b0);
    run(3'h3, 1'b0, 9, 1'b0);
    run(3'h4, 1'b0, 7, 1'b0);
    run(3'h4, 1'b0, 6, 1'b0);
    run(3'h5, 1'b0, 31, 1'b0);
    run(3'h5, 1'b0, 30, 1'b0);
    run(3'h6, 1'b1, 5, 1'b0);
    run(3'h6, 1'b0, 5, 1'b0);
    run(3'h7, 1'b0, 6, 1'b0);
    run(3'h7, 1'b0, 6, 1'b1);
    for (int k = 0; k < 12; k++) begin
      run(3'($urandom % 8), 1'($urandom % 2), 1 + ($urandom % 40),
          1'($urandom % 2));
    end
    // time base runs only while a mode is selected
    wr(`ICMS_OFF_CTRL, 32'h1);
    rd(`ICMS_OFF_TIME, t1);
    rd(`ICMS_OFF_TIME, d);
    chk((d - t1) & 32'hffff, 32'h2);
    wr(`ICMS_OFF_CTRL, 32'h0);
    rd(`ICMS_OFF_TIME, t1);
    rd(`ICMS_OFF_TIME, d);
    chk(d - t1, 32'h0);
    // overflow left standing while masked, then unmasked and cleared
    run(3'h3, 1'b0, 4, 1'b0);
    chk({31'h0, irq}, 32'h0);
    wr(`ICMS_OFF_MASK, 32'h2);
    repeat (2) @(posedge clk_in);
    chk({31'h0, irq}, 32'h1);
    wr(`ICMS_OFF_STAT, 32'h2);
    repeat (2) @(posedge clk_in);
    chk({31'h0, irq}, 32'h0);
    rd(`ICMS_OFF_STAT, d);
    chk(d, 32'h0);
    // unmapped places read zero and ignore writes
    wr(`ICMS_OFF_CTRL, 32'hffff_fff3);
    wr(8'h14, 32'h5);
    rd(`ICMS_OFF_CTRL, d);
    chk(d, 32'h3);
    rd(8'h20, d);
    chk(d, 32'h0);
    end_sim();
  end
endmodule : tb_top
`default_nettype wire
